/* File: port_a_pkg.sv */
package port_a_pkg;

    // Port geometry
    localparam int PIN_COUNT        = 8;
    localparam int PORT_COUNT       = 2;
    localparam int PORT_A_INDEX     = 0;

    // Pin positions on port A
    localparam int REF_PIN          = 7;
    localparam int SELECT_PIN       = 6;
    localparam int CLOCK_PIN        = 5;
    localparam int DATA_IN_PIN      = 4;

    // Bit position of the global pull-up disable in the core control register
    localparam int GLOBAL_PULLUP_OFF_BIT = 4;

    // Converter reference selection codes
    localparam logic [1:0] REF_SEL_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_SEL_SUPPLY   = 2'h1;
    localparam logic [1:0] REF_SEL_INT_LOW  = 2'h2;
    localparam logic [1:0] REF_SEL_INT_HIGH = 2'h3;

    // Reset values of the output state
    localparam logic [7:0] PULLUP_RESET     = 8'h00;
    localparam logic [7:0] DRIVE_RESET      = 8'h00;
    localparam logic [7:0] LEVEL_RESET      = 8'h00;

    // Reference use modes of pin 7
    typedef enum logic [1:0] {
        REF_USE_NONE,
        REF_USE_DRIVE,
        REF_USE_EXTERNAL,
        REF_USE_BYPASS
    } ref_use_type;

endpackage

/* File: pin_override.sv */
`timescale 1ns/100ps
`default_nettype none

// One pin's override merge: direction, output value and pull-up
module pin_override
    import port_a_pkg::*;
(
    input  wire logic direction,
    input  wire logic output_latch,
    input  wire logic pullup_off,
    input  wire logic dir_force_en,
    input  wire logic dir_force_val,
    input  wire logic pullup_force_en,
    input  wire logic pullup_force_val,
    input  wire logic analog_only,
    output logic      drive_en,
    output logic      drive_level,
    output logic      pullup_en
);

    // Direction override first, analog use kills the driver
    always_comb begin
        drive_en = dir_force_en ? dir_force_val : direction;
        if (analog_only) begin
            drive_en = 1'b0;
        end
    end

    // Output value always from the latch here
    assign drive_level = output_latch;

    // Plain pull-up: input, latch high, no disable; overrides win
    always_comb begin
        if (analog_only) begin
            pullup_en = 1'b0;
        end else if (pullup_force_en) begin
            pullup_en = pullup_force_val;
        end else begin
            pullup_en = ~drive_en & output_latch & ~pullup_off;
        end
    end

endmodule

`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a vector of pin levels
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] first_stage;

    // A vector needs at least one bit
    if (WIDTH < 1) begin : g_check_width
        $error("Synchroniser width must be at least 1");
    end

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_stage <= '0;
            sync_out    <= '0;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end

endmodule

`default_nettype wire

/* File: port_a_alternate_pin_control.sv */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - A port's pull-up-off bit kills all its pull-ups, even input with latch high.
// - Effective pull-up-off is port bit OR the global bit.
// - Pin 7 drives internal reference only if enabled and an internal reference selected.
// - While pin 7 drives the reference, its pull-up and driver are off.
// - Pin 7 as external reference or bypass capacitor: pull-up and driver off.
// - Pin 7 goes to comparator plus, pin 6 to minus, no port logic between.
// - SPI slave forces pin 6 to input.
// - SPI master leaves pin 6 direction to its direction bit.
// - Forced-input pin 6 pull-up still follows latch bit and disables.
// - SPI slave forces pin 5 to input.
// - SPI master leaves pin 5 direction to its direction bit.
// - Forced-input pin 5 pull-up still follows its latch bit.
// - SPI slave forces pin 4 to input.
// - SPI master leaves pin 4 direction to its direction bit.
// - Forced-input pin 4 pull-up still follows its latch bit.
// - Three-wire serial input overrides nothing; software sets pin 4 input.
// - Each pin n feeds pin-change source n; pin 7 feeds source 7.
// - Global pull-up-off bit, bit 4 of core control, disables all ports.
module port_a_alternate_pin_control
    import port_a_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            pin_direction_bit,
    input  wire logic [7:0]            pin_output_latch_bit,
    input  wire logic [PORT_COUNT-1:0] port_pullup_off_bits,
    input  wire logic [7:0]            core_control_register,
    input  wire logic                  ref_drive_enable,
    input  wire logic [1:0]            ref_select,
    input  wire logic                  ref_bypass_only,
    input  wire logic                  spi_enable,
    input  wire logic                  spi_master,
    input  wire logic [7:0]            pin_in,
    input  wire logic                  pin7_analog,
    input  wire logic                  pin6_analog,
    output logic      [7:0]            pin_out,
    output logic      [7:0]            pin_oe,
    output logic      [7:0]            pin_pullup,
    output logic      [PORT_COUNT-1:0] pullup_off_effective,
    output logic                       internal_ref_output,
    output logic                       external_ref_input,
    output logic                       comparator_plus_input,
    output logic                       comparator_minus_input,
    output logic      [7:0]            pin_change_source,
    output logic                       three_wire_serial_in,
    output logic                       spi_select_n,
    output logic                       spi_clock_in,
    output logic                       spi_data_in
);

    logic       global_pullup_off;
    logic       port_a_off;
    logic       internal_ref;
    ref_use_type ref_use;
    logic       spi_slave;
    logic [7:0] dir_force_en;
    logic [7:0] dir_force_val;
    logic [7:0] analog_only;
    logic [7:0] next_oe;
    logic [7:0] next_out;
    logic [7:0] next_pullup;
    logic [7:0] pin_sampled;
    logic       spi_master_role;
    logic       force_select_in;
    logic       force_clock_in;
    logic       force_data_in;
    logic       ref_drive_active;
    logic       ref_external_active;
    logic       ref_bypass_active;
    logic [7:0] pin_pullup_off;

    // Single-pin masks built from the package positions
    localparam logic [7:0] REF_MASK    = 8'h01 << REF_PIN;
    localparam logic [7:0] SELECT_MASK = 8'h01 << SELECT_PIN;
    localparam logic [7:0] CLOCK_MASK  = 8'h01 << CLOCK_PIN;
    localparam logic [7:0] DATA_MASK   = 8'h01 << DATA_IN_PIN;

    // Port vectors are fixed at eight bits
    if (PIN_COUNT != 8) begin : g_check_pin_count
        $error("Pin count must be 8 to match the port vectors");
    end

    // Port A needs a place in the disable vector
    if (PORT_A_INDEX >= PORT_COUNT) begin : g_check_port_index
        $error("Port A index lies outside the disable vector");
    end

    // Global disable must sit inside the control byte
    if (GLOBAL_PULLUP_OFF_BIT > 7) begin : g_check_global_bit
        $error("Global pull-up disable bit lies outside the control byte");
    end

    // Reset must leave every driver off
    if (DRIVE_RESET != 8'h00) begin : g_check_drive_reset
        $error("Driver enables must be clear in reset");
    end

    // Reset must leave every pull-up off
    if (PULLUP_RESET != 8'h00) begin : g_check_pullup_reset
        $error("Pull-up enables must be clear in reset");
    end

    // Reset levels match the cleared output latch
    if (LEVEL_RESET != 8'h00) begin : g_check_level_reset
        $error("Output levels must be low in reset");
    end

    // Reference pin must exist on the port
    if (REF_PIN >= PIN_COUNT) begin : g_check_ref_pin
        $error("Reference pin lies outside the port");
    end

    // Select pin must exist on the port
    if (SELECT_PIN >= PIN_COUNT) begin : g_check_select_pin
        $error("Select pin lies outside the port");
    end

    // Clock pin must exist on the port
    if (CLOCK_PIN >= PIN_COUNT) begin : g_check_clock_pin
        $error("Clock pin lies outside the port");
    end

    // Data pin must exist on the port
    if (DATA_IN_PIN >= PIN_COUNT) begin : g_check_data_pin
        $error("Data pin lies outside the port");
    end

    // Reference pin carries no SPI function
    if (((SELECT_MASK | CLOCK_MASK | DATA_MASK) & REF_MASK) != 8'h00) begin : g_check_ref_apart
        $error("Reference pin overlaps an SPI pin");
    end

    // Select and clock need pins of their own
    if (SELECT_PIN == CLOCK_PIN) begin : g_check_select_clock
        $error("Select and clock share a pin");
    end

    // Clock and data need pins of their own
    if (CLOCK_PIN == DATA_IN_PIN) begin : g_check_clock_data
        $error("Clock and data share a pin");
    end

    // Select and data need pins of their own
    if (SELECT_PIN == DATA_IN_PIN) begin : g_check_select_data
        $error("Select and data share a pin");
    end

    // Reference selection codes must all differ
    if ((4'h1 << REF_SEL_EXTERNAL | 4'h1 << REF_SEL_SUPPLY | 4'h1 << REF_SEL_INT_LOW
         | 4'h1 << REF_SEL_INT_HIGH) != 4'hF) begin : g_check_ref_codes
        $error("Reference selection codes must be distinct");
    end

    // Global disable bit from the core control register
    assign global_pullup_off = core_control_register[GLOBAL_PULLUP_OFF_BIT];

    // Per-port effective disable: port bit OR global bit
    assign pullup_off_effective = port_pullup_off_bits | {PORT_COUNT{global_pullup_off}};
    assign port_a_off = pullup_off_effective[PORT_A_INDEX];

    // Internal reference is one of the two internal selections
    assign internal_ref = (ref_select == REF_SEL_INT_LOW) || (ref_select == REF_SEL_INT_HIGH);

    // Pin 7 reference use per selection; drive beats bypass
    always_comb begin
        ref_use = REF_USE_NONE;
        case (ref_select)
            REF_SEL_EXTERNAL: begin
                ref_use = REF_USE_EXTERNAL;
            end
            REF_SEL_INT_LOW, REF_SEL_INT_HIGH: begin
                if (ref_drive_enable && internal_ref) begin
                    ref_use = REF_USE_DRIVE;
                end else if (ref_bypass_only) begin
                    ref_use = REF_USE_BYPASS;
                end
            end
            REF_SEL_SUPPLY: begin
                if (ref_bypass_only) begin
                    ref_use = REF_USE_BYPASS;
                end
            end
            default: begin
                ref_use = REF_USE_NONE;
            end
        endcase
    end

    // Reference state towards the converter side
    assign internal_ref_output = (ref_use == REF_USE_DRIVE);
    assign external_ref_input  = (ref_use == REF_USE_EXTERNAL);

    // Role decode: a slave forces pins 6..4 in, a master leaves them
    assign spi_slave       = spi_enable & ~spi_master;
    assign spi_master_role = spi_enable & spi_master;

    // Select pin: slave forces input, master keeps its bit
    always_comb begin
        case ({spi_slave, spi_master_role})
            2'h2: begin
                force_select_in = 1'b1;
            end
            2'h1: begin
                force_select_in = 1'b0;
            end
            default: begin
                force_select_in = 1'b0;
            end
        endcase
    end

    // Clock pin: slave forces input, master keeps its bit
    always_comb begin
        case ({spi_slave, spi_master_role})
            2'h2: begin
                force_clock_in = 1'b1;
            end
            2'h1: begin
                force_clock_in = 1'b0;
            end
            default: begin
                force_clock_in = 1'b0;
            end
        endcase
    end

    // Data pin: slave forces input, master keeps its bit
    always_comb begin
        case ({spi_slave, spi_master_role})
            2'h2: begin
                force_data_in = 1'b1;
            end
            2'h1: begin
                force_data_in = 1'b0;
            end
            default: begin
                force_data_in = 1'b0;
            end
        endcase
    end

    // Direction override vector; forced pins always read as inputs
    always_comb begin
        dir_force_en  = ({8{force_select_in}} & SELECT_MASK)
                      | ({8{force_clock_in}} & CLOCK_MASK)
                      | ({8{force_data_in}} & DATA_MASK);
        dir_force_val = 8'h00;
    end

    // Every port A pin shares its port's combined disable
    always_comb begin
        pin_pullup_off = 8'h00;
        for (int p = 0; p < PIN_COUNT; p++) begin
            pin_pullup_off[p] = port_a_off;
        end
    end

    // Reference uses of pin 7, one flag each
    assign ref_drive_active    = (ref_use == REF_USE_DRIVE);
    assign ref_external_active = (ref_use == REF_USE_EXTERNAL);
    assign ref_bypass_active   = (ref_use == REF_USE_BYPASS);

    // Any analog use of pin 7 takes its driver and pull-up away
    always_comb begin
        analog_only = 8'h00;
        if (ref_drive_active) begin
            analog_only = REF_MASK;
        end
        if (ref_external_active || ref_bypass_active) begin
            analog_only = REF_MASK;
        end
    end

    // One override merge per pin; forced inputs keep latch-controlled pull-up
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            pin_override u_override (
                .direction        (pin_direction_bit[gi]),
                .output_latch     (pin_output_latch_bit[gi]),
                .pullup_off       (pin_pullup_off[gi]),
                .dir_force_en     (dir_force_en[gi]),
                .dir_force_val    (dir_force_val[gi]),
                .pullup_force_en  (1'b0),
                .pullup_force_val (1'b0),
                .analog_only      (analog_only[gi]),
                .drive_en         (next_oe[gi]),
                .drive_level      (next_out[gi]),
                .pullup_en        (next_pullup[gi])
            );
        end
    endgenerate

    // Driver enables; no pin drives during reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_oe <= DRIVE_RESET;
        end else begin
            pin_oe <= next_oe;
        end
    end

    // Output levels follow the latch one cycle later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= LEVEL_RESET;
        end else begin
            pin_out <= next_out;
        end
    end

    // Pull-up enables; all off during reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_pullup <= PULLUP_RESET;
        end else begin
            pin_pullup <= next_pullup;
        end
    end

    // Pin levels pass two flip-flops before digital consumers
    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (pin_in),
        .sync_out (pin_sampled)
    );

    // Pin n feeds pin-change source n
    assign pin_change_source = pin_sampled;

    // Slave select, active low from the outside master
    assign spi_select_n         = pin_sampled[SELECT_PIN];

    // Serial clock and data into the SPI
    assign spi_clock_in         = pin_sampled[CLOCK_PIN];
    assign spi_data_in          = pin_sampled[DATA_IN_PIN];

    // Three-wire input taps the same pad as SPI data
    assign three_wire_serial_in = pin_sampled[DATA_IN_PIN];

    // Comparator inputs straight from the pad, no port logic
    assign comparator_plus_input  = pin7_analog;
    assign comparator_minus_input = pin6_analog;

endmodule

`default_nettype wire

/* File: port_a_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module port_a_chk
    import port_a_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic [7:0]            pin_direction_bit,
    input wire logic [7:0]            pin_output_latch_bit,
    input wire logic [PORT_COUNT-1:0] port_pullup_off_bits,
    input wire logic [7:0]            core_control_register,
    input wire logic                  ref_drive_enable,
    input wire logic [1:0]            ref_select,
    input wire logic                  ref_bypass_only,
    input wire logic                  spi_enable,
    input wire logic                  spi_master,
    input wire logic [7:0]            pin_in,
    input wire logic                  pin7_analog,
    input wire logic                  pin6_analog,
    input wire logic [7:0]            pin_oe,
    input wire logic [7:0]            pin_pullup,
    input wire logic [PORT_COUNT-1:0] pullup_off_effective,
    input wire logic                  internal_ref_output,
    input wire logic                  comparator_plus_input,
    input wire logic                  comparator_minus_input,
    input wire logic [7:0]            pin_change_source
);
    // One clock domain, muted in reset
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic off_a = pullup_off_effective[PORT_A_INDEX];
    a_off_merge: assert property (pullup_off_effective == (port_pullup_off_bits
        | {PORT_COUNT{core_control_register[GLOBAL_PULLUP_OFF_BIT]}})) else $error("merge");
    a_port_kill: assert property (port_pullup_off_bits[PORT_A_INDEX] |=> pin_pullup == 8'h00)
        else $error("port off");
    a_global_kill: assert property (core_control_register[GLOBAL_PULLUP_OFF_BIT]
        |=> pin_pullup == 8'h00) else $error("global off");
    a_ref_drive: assert property (internal_ref_output == (ref_drive_enable && ref_select[1]))
        else $error("ref drive");
    a_ref_quiet: assert property ((internal_ref_output || ref_select == 2'h0 || ref_bypass_only)
        |=> !pin_oe[REF_PIN] && !pin_pullup[REF_PIN]) else $error("ref pin");
    a_comp_wire: assert property (comparator_plus_input == pin7_analog
        && comparator_minus_input == pin6_analog) else $error("comparator");
    a_slave_force: assert property (spi_enable && !spi_master |=> pin_oe[6:4] == 3'h0
        && pin_pullup[6:4] == $past(pin_output_latch_bit[6:4] & ~{3{off_a}})) else $error("slave");
    a_master_dir: assert property (spi_enable && spi_master
        |=> pin_oe[6:4] == $past(pin_direction_bit[6:4])) else $error("master");
    a_plain_pins: assert property (1 |=> pin_oe[3:0] == $past(pin_direction_bit[3:0])
        && pin_pullup[3:0] == $past(~pin_direction_bit[3:0] & pin_output_latch_bit[3:0]
        & ~{4{off_a}})) else $error("plain pins");
    a_sync_delay: assert property (!$past(rst) && !$past(rst, 2)
        |-> pin_change_source == $past(pin_in, 2)) else $error("sync");
endmodule
bind port_a_alternate_pin_control port_a_chk u_chk (.clk, .rst, .pin_direction_bit,
    .pin_output_latch_bit, .port_pullup_off_bits, .core_control_register, .ref_drive_enable,
    .ref_select, .ref_bypass_only, .spi_enable, .spi_master, .pin_in, .pin7_analog, .pin6_analog,
    .pin_oe, .pin_pullup, .pullup_off_effective, .internal_ref_output, .comparator_plus_input,
    .comparator_minus_input, .pin_change_source);
`default_nettype wire

/* File: pad_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pad_model (
    input  wire logic       select_active,
    input  wire logic [7:0] level,
    output logic      [7:0] pin_in,
    output logic            pin7_analog,
    output logic            pin6_analog
);
    // Pad levels; an outside master pulls select low to pick the slave
    always_comb begin
        pin_in = {level[7], ~select_active, level[5:0]};
        pin7_analog = level[7];
        pin6_analog = ~select_active; // Same pad as the select level
    end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import port_a_pkg::*;
    logic       clk, rst, ref_drive_enable, ref_bypass_only, spi_enable, spi_master, select_active;
    logic       pin7_analog, pin6_analog, internal_ref_output, external_ref_input, spi_select_n;
    logic       comparator_plus_input, comparator_minus_input, three_wire_serial_in;
    logic       spi_clock_in, spi_data_in;
    logic [7:0] pin_direction_bit, pin_output_latch_bit, core_control_register, level;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_change_source;
    logic [1:0] ref_select, port_pullup_off_bits, pullup_off_effective;
    int         fails, total_checks;
    port_a_alternate_pin_control u_dut (.clk, .rst, .pin_direction_bit, .pin_output_latch_bit,
        .port_pullup_off_bits, .core_control_register, .ref_drive_enable, .ref_select,
        .ref_bypass_only, .spi_enable, .spi_master, .pin_in, .pin7_analog, .pin6_analog, .pin_out,
        .pin_oe, .pin_pullup, .pullup_off_effective, .internal_ref_output, .external_ref_input,
        .comparator_plus_input, .comparator_minus_input, .pin_change_source,
        .three_wire_serial_in, .spi_select_n, .spi_clock_in, .spi_data_in);
    pad_model u_pads (.select_active, .level, .pin_in, .pin7_analog, .pin6_analog);
    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Settings then one edge; ctl is drive, bypass, spi on, master
    task automatic cfg(input logic [7:0] d, l, input logic [1:0] o, input logic [7:0] c,
                       input logic [3:0] ctl, input logic [1:0] s);
        pin_direction_bit = d;
        pin_output_latch_bit = l;
        port_pullup_off_bits = o;
        core_control_register = c;
        {ref_drive_enable, ref_bypass_only, spi_enable, spi_master} = ctl;
        ref_select = s;
        @(posedge clk);
        #10;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (400) @(posedge clk);
        fails++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        select_active = 1'b0;
        level = 8'h00;
        cfg(8'h00, 8'h00, 2'h0, 8'h00, 4'h0, 2'h0);
        repeat (7) @(posedge clk);
        #10;
        chk(pin_oe | pin_pullup, 8'h00);
        rst = 1'b0;
        cfg(8'h00, 8'hFF, 2'h0, 8'h00, 4'h0, REF_SEL_SUPPLY);
        chk(pin_pullup, 8'hFF);
        cfg(8'h00, 8'hFF, 2'h1, 8'h00, 4'h0, REF_SEL_SUPPLY);
        chk(pin_pullup, 8'h00);
        chk(pullup_off_effective, 8'h01);
        cfg(8'h00, 8'hFF, 2'h2, 8'hEF, 4'h0, REF_SEL_SUPPLY);
        chk(pin_pullup, 8'hFF);
        cfg(8'h00, 8'hFF, 2'h0, 8'h10, 4'h0, REF_SEL_SUPPLY);
        chk(pin_pullup, 8'h00);
        chk(pullup_off_effective, 8'h03);
        for (int s = 0; s < 4; s++) begin
            cfg(8'hFF, 8'hFF, 2'h0, 8'h00, 4'h8, s[1:0]);
            chk(internal_ref_output, s >= 2);
            chk(pin_oe, {s == 1, 7'h7F});
            chk(external_ref_input, s == 0);
        end
        cfg(8'h00, 8'hFF, 2'h0, 8'h00, 4'h8, REF_SEL_INT_HIGH);
        chk(pin_pullup, 8'h7F);
        cfg(8'hFF, 8'hFF, 2'h0, 8'h00, 4'h4, REF_SEL_SUPPLY);
        chk(pin_oe, 8'h7F);
        cfg(8'hFF, 8'hAF, 2'h0, 8'h00, 4'h2, REF_SEL_SUPPLY);
        chk(pin_oe, 8'h8F);
        chk(pin_out, 8'hAF);
        chk(pin_pullup, 8'h20);
        cfg(8'hA0, 8'hFF, 2'h0, 8'h00, 4'h3, REF_SEL_SUPPLY);
        chk(pin_oe, 8'hA0);
        cfg(8'h10, 8'hFF, 2'h0, 8'h00, 4'h0, REF_SEL_SUPPLY);
        chk(pin_oe, 8'h10);
        chk(pin_pullup, 8'hEF);
        level = 8'hA5;
        select_active = 1'b1;
        repeat (2) @(posedge clk);
        #10;
        chk(pin_change_source, 8'hA5);
        chk(spi_select_n, 8'h00);
        chk({comparator_plus_input, comparator_minus_input}, 8'h02);
        chk({three_wire_serial_in, spi_clock_in, spi_data_in}, 8'h02);
        level = 8'h1A;
        select_active = 1'b0;
        @(posedge clk);
        #10;
        chk(pin_change_source, 8'hA5);
        @(posedge clk);
        #10;
        chk(pin_change_source, 8'h5A);
        chk(spi_select_n, 8'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
